// ==== logic/acs_consts.svh ====
// Offsets, field positions and timing counts of the conversion sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_OFF_CTRLA 8'h00
`define ACS_OFF_CTRLB 8'h04
`define ACS_OFF_CHREF 8'h08
`define ACS_OFF_RESL 8'h0C
`define ACS_OFF_RESH 8'h10
`define ACS_OFF_PWR 8'h14
`define ACS_A_EN 0
`define ACS_A_START 1
`define ACS_A_AUTO 2
`define ACS_A_DONE 3
`define ACS_A_PSEL 4
`define ACS_B_TSRC 0
`define ACS_C_CHAN 0
`define ACS_C_LEFT 5
`define ACS_C_REF 6
`define ACS_P_PRED 0
`define ACS_TSRC_FREE 3'h0
`define ACS_SYNC_STAGES 3
`define ACS_NORM_SH 6'h03
`define ACS_NORM_LEN 6'h1A
`define ACS_FIRST_SH 6'h1B
`define ACS_FIRST_LEN 6'h32
`define ACS_AUTO_SH 6'h04
`define ACS_AUTO_LEN 6'h1B
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2
`endif

// ==== logic/acs_pkg.sv ====
// Types of the conversion sequencer
package acs_pkg;
  typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} acs_state_e;
  typedef enum logic [1:0] {
    KIND_NORMAL = 2'b00,
    KIND_FIRST = 2'b01,
    KIND_AUTO = 2'b10
  } acs_kind_e;
  typedef struct packed {
    logic awRdy;
    logic awHave;
    logic [7:0] awAddr;
    logic wRdy;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic en;
    logic autoEn;
    logic [2:0] psel;
    logic [2:0] tsrc;
    logic pwrRed;
    logic anaEn;
    logic [3:0] chanBuf;
    logic [1:0] refBuf;
    logic leftAlign;
    logic [3:0] chanApp;
    logic [1:0] refApp;
    logic doneFlag;
    logic pendStart;
    logic firstPend;
    logic lock;
    logic [9:0] result;
    logic [8:0] presc;
    logic convClk;
    acs_state_e state;
    logic busy;
    acs_kind_e kind;
    logic [5:0] halfCnt;
    logic sampleHold;
    logic doneEvt;
    logic [2:0] trigPipe;
    logic trigPrev;
  } acs_regs_s;
endpackage : acs_pkg

// ==== logic/acs_sequencer.sv ====
// Conversion sequencer of a 10-bit SAR converter with AXI4-Lite registers
//
// Behaviour
// - Result right-aligned, left-aligned when selected
// - Low byte read blocks result updates
// - High byte read lifts the block
// - Done flag set even for discarded results
// - Start bit held while converting, then cleared
// - Channel change waits for running conversion
// - Selections apply only while enabled
// - Trigger edge resets prescaler, starts conversion
// - Edges during conversion ignored, no level restart
// - Trigger flags set regardless; software clears them
// - Own done flag as trigger: back-to-back
// - Start write works under auto trigger
// - Prescaler runs only while enabled
// - Software start waits next converter rising edge
// - 13 cycles normal, 25 first after enable
// - Hold at 1.5 or 13.5 cycles
// - End: write result, flag, clear start
// - Auto: hold at 2, length 13.5
// - Three CPU cycles trigger synchronisation
// - Free running restarts at once, start stays
// - Selection locked from start till last cycle
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_sequencer #(
  parameter int TRIG_N = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Trigger sources, index 0 unused (own done flag)
  input wire logic [TRIG_N-1:0] trigIn,
  // Analog side
  input wire logic [9:0] resultIn,
  output logic analogEnable,
  output logic convClock,
  output logic sampleHold,
  output logic convActive,
  output logic [3:0] channelSelect,
  output logic [1:0] referenceSelect,
  output logic conversionDoneFlag
);
  import acs_pkg::*;

  acs_regs_s r;
  acs_regs_s n;

  // Half-cycle hold point of each conversion kind
  function automatic logic [5:0] shPoint(input acs_kind_e k);
    if (k == KIND_FIRST) shPoint = `ACS_FIRST_SH;
    else if (k == KIND_AUTO) shPoint = `ACS_AUTO_SH;
    else shPoint = `ACS_NORM_SH;
  endfunction : shPoint

  // Half-cycle length of each conversion kind
  function automatic logic [5:0] halfLen(input acs_kind_e k);
    if (k == KIND_FIRST) halfLen = `ACS_FIRST_LEN;
    else if (k == KIND_AUTO) halfLen = `ACS_AUTO_LEN;
    else halfLen = `ACS_NORM_LEN;
  endfunction : halfLen

  // Register decode shared by write and read paths
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `ACS_OFF_CTRLA) || (a == `ACS_OFF_CTRLB) ||
               (a == `ACS_OFF_CHREF) || (a == `ACS_OFF_RESL) ||
               (a == `ACS_OFF_RESH) || (a == `ACS_OFF_PWR);
  endfunction : isMapped

  logic enEff;
  logic [8:0] divLen;
  logic rise;
  logic fall;
  logic trigEdge;
  logic freeRun;
  logic wrFire;
  logic startWr;
  logic doneClr;
  logic [9:0] aligned;
  logic [5:0] nextHalf;

  // Next-state logic for the whole block
  always_comb
  begin
    n = r;
    n.doneEvt = 1'b0;
    n.sampleHold = 1'b0;
    startWr = 1'b0;
    doneClr = 1'b0;
    enEff = r.en & ~r.pwrRed;
    freeRun = r.autoEn && (r.tsrc == `ACS_TSRC_FREE);
    divLen = 9'(10'h002 << r.psel);
    rise = r.presc == 9'(divLen - 9'h001);
    fall = r.presc == 9'((divLen >> 1) - 9'h001);
    nextHalf = 6'(r.halfCnt + 6'h01);
    aligned = r.leftAlign ? {r.result[1:0], r.result[9:2]} : r.result;

    // Write address and data taken in either order
    if (awvalid && r.awRdy)
    begin
      n.awAddr = awaddr;
      n.awHave = 1'b1;
    end
    if (wvalid && r.wRdy)
    begin
      n.wData = wdata;
      n.wStrb = wstrb;
      n.wHave = 1'b1;
    end
    wrFire = r.awHave && r.wHave && !r.bValid;
    if (wrFire)
    begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = isMapped(r.awAddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      // All fields sit in byte lane 0
      if (!r.wStrb[0])
        n.bResp = n.bResp;
      else if (r.awAddr == `ACS_OFF_CTRLA)
      begin
        n.en = r.wData[`ACS_A_EN];
        n.autoEn = r.wData[`ACS_A_AUTO];
        n.psel = r.wData[`ACS_A_PSEL +: 3];
        startWr = r.wData[`ACS_A_START];
        doneClr = r.wData[`ACS_A_DONE];
      end
      else if (r.awAddr == `ACS_OFF_CTRLB)
        n.tsrc = r.wData[`ACS_B_TSRC +: 3];
      else if (r.awAddr == `ACS_OFF_CHREF)
      begin
        n.chanBuf = r.wData[`ACS_C_CHAN +: 4];
        n.leftAlign = r.wData[`ACS_C_LEFT];
        n.refBuf = r.wData[`ACS_C_REF +: 2];
      end
      else if (r.awAddr == `ACS_OFF_PWR)
        n.pwrRed = r.wData[`ACS_P_PRED];
    end
    if (r.bValid && bready)
      n.bValid = 1'b0;
    n.awRdy = !n.awHave && !n.bValid;
    n.wRdy = !n.wHave && !n.bValid;

    // Read path; result reads also move the lock
    if (arvalid && r.arRdy)
    begin
      n.arRdy = 1'b0;
      n.rValid = 1'b1;
      n.rResp = isMapped(araddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      n.rData = 32'h0000_0000;
      if (araddr == `ACS_OFF_CTRLA)
        n.rData[7:0] = {1'b0, r.psel, r.doneFlag, r.autoEn,
                        r.busy | r.pendStart, r.en};
      else if (araddr == `ACS_OFF_CTRLB)
        n.rData[2:0] = r.tsrc;
      else if (araddr == `ACS_OFF_CHREF)
        n.rData[7:0] = {r.refBuf, r.leftAlign, 1'b0, r.chanBuf};
      else if (araddr == `ACS_OFF_RESL)
      begin
        n.rData[7:0] = r.leftAlign ? {aligned[9:8], 6'h00}
                                   : aligned[7:0];
        n.lock = 1'b1;
      end
      else if (araddr == `ACS_OFF_RESH)
      begin
        n.rData[7:0] = r.leftAlign ? aligned[7:0]
                                   : {6'h00, aligned[9:8]};
        n.lock = 1'b0;
      end
      else if (araddr == `ACS_OFF_PWR)
        n.rData[0] = r.pwrRed;
    end
    if (r.rValid && rready)
    begin
      n.rValid = 1'b0;
      n.arRdy = 1'b1;
    end

    // Prescaler and divided clock, held cleared while disabled
    if (!enEff)
    begin
      n.presc = 9'h000;
      n.convClk = 1'b0;
    end
    else
    begin
      n.presc = rise ? 9'h000 : 9'(r.presc + 9'h001);
      if (rise)
        n.convClk = 1'b1;
      else if (fall)
        n.convClk = 1'b0;
    end

    // Fixed three-stage delay gives a known trigger latency
    n.trigPipe = {r.trigPipe[1:0], trigIn[r.tsrc]};
    n.trigPrev = r.trigPipe[`ACS_SYNC_STAGES-1];
    trigEdge = r.trigPipe[`ACS_SYNC_STAGES-1] && !r.trigPrev &&
               r.autoEn && !freeRun && enEff;

    if (startWr && enEff)
      n.pendStart = 1'b1;
    if (doneClr)
      n.doneFlag = 1'b0;

    // Channel and reference follow the buffer outside conversion while enabled
    if (enEff && (r.state == ST_IDLE ||
        r.halfCnt >= 6'(halfLen(r.kind) - 6'h02)))
    begin
      n.chanApp = r.chanBuf;
      n.refApp = r.refBuf;
    end

    // Conversion sequencing
    case (r.state)
      ST_IDLE:
      begin
        if (trigEdge)
        begin
          n.state = ST_CONV;
          n.kind = r.firstPend ? KIND_FIRST : KIND_AUTO;
          n.halfCnt = 6'h00;
          n.presc = 9'h000;
          n.convClk = 1'b0;
        end
        else if (r.pendStart && enEff && rise)
        begin
          n.state = ST_CONV;
          n.kind = r.firstPend ? KIND_FIRST : KIND_NORMAL;
          n.halfCnt = 6'h00;
          n.pendStart = 1'b0;
        end
      end
      ST_CONV:
      begin
        // Trigger edges are not looked at here
        if (enEff && (rise || fall))
        begin
          n.halfCnt = nextHalf;
          if (nextHalf == shPoint(r.kind))
            n.sampleHold = 1'b1;
          if (nextHalf == halfLen(r.kind))
          begin
            n.doneEvt = 1'b1;
            n.doneFlag = 1'b1;
            n.firstPend = 1'b0;
            if (!r.lock)
              n.result = resultIn;
            if (freeRun)
            begin
              n.kind = KIND_NORMAL;
              n.halfCnt = 6'h00;
            end
            else
              n.state = ST_IDLE;
          end
        end
      end
      default: n.state = ST_IDLE;
    endcase

    // Disable aborts and rearms the long first conversion
    if (!enEff)
    begin
      n.state = ST_IDLE;
      n.pendStart = 1'b0;
      n.firstPend = 1'b1;
    end
    n.busy = n.state == ST_CONV;
    n.anaEn = n.en & ~n.pwrRed;
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.awRdy <= 1'b1;
      r.wRdy <= 1'b1;
      r.arRdy <= 1'b1;
      r.firstPend <= 1'b1;
    end
    else
      r <= n;
  end

  // Outputs straight from the state register
  assign awready = r.awRdy;
  assign wready = r.wRdy;
  assign bvalid = r.bValid;
  assign bresp = r.bResp;
  assign arready = r.arRdy;
  assign rvalid = r.rValid;
  assign rdata = r.rData;
  assign rresp = r.rResp;
  assign analogEnable = r.anaEn;
  assign convClock = r.convClk;
  assign sampleHold = r.sampleHold;
  assign convActive = r.busy;
  assign channelSelect = r.chanApp;
  assign referenceSelect = r.refApp;
  assign conversionDoneFlag = r.doneFlag;

  // Checks
  sequence sEnd;
    r.doneEvt;
  endsequence
  sequence sStart;
    !r.busy ##1 r.busy;
  endsequence

  a_lock_blocks_write: assert property (@(posedge clock) disable iff (!rstn)
    (r.doneEvt && $past(r.lock)) |-> $stable(r.result))
    else $error("Result changed while blocked");
  a_high_read_unlock: assert property (@(posedge clock) disable iff (!rstn)
    (arvalid && r.arRdy && araddr == `ACS_OFF_RESH) |=> !r.lock)
    else $error("Lock kept after high read");
  a_done_every_end: assert property (@(posedge clock) disable iff (!rstn)
    sEnd |-> r.doneFlag)
    else $error("Done flag not set at end");
  a_start_clears: assert property (@(posedge clock) disable iff (!rstn)
    (sEnd and !$past(freeRun)) |-> !r.busy)
    else $error("Busy kept after single conversion");
  a_chan_locked: assert property (@(posedge clock) disable iff (!rstn)
    (r.busy && r.halfCnt < 6'(halfLen(r.kind) - 6'h02) && n.busy)
    |=> $stable(r.chanApp))
    else $error("Channel changed mid conversion");
  a_presc_held: assert property (@(posedge clock) disable iff (!rstn)
    !(r.en && !r.pwrRed) |=> (r.presc == 9'h000 && !r.busy))
    else $error("Prescaler runs while disabled");
  a_conv_length: assert property (@(posedge clock) disable iff (!rstn)
    sEnd |-> r.halfCnt == halfLen($past(r.kind))
             || (r.halfCnt == 6'h00 && r.busy))
    else $error("Conversion length wrong");
  a_hold_point: assert property (@(posedge clock) disable iff (!rstn)
    r.sampleHold |-> r.halfCnt == shPoint(r.kind))
    else $error("Hold at wrong point");
  a_trig_ignored: assert property (@(posedge clock) disable iff (!rstn)
    (r.busy && trigEdge && n.busy && !n.doneEvt)
    |=> (r.presc != 9'h000 || $past(rise)))
    else $error("Edge restarted conversion");
  a_sw_start_edge: assert property (@(posedge clock) disable iff (!rstn)
    sStart |-> ($past(rise)
                || $past(trigEdge)))
    else $error("Start off converter edge");
endmodule : acs_sequencer

// ==== test/acs_analog_model.sv ====
// Behavioural multiplexer, sample-and-hold and comparator of the converter
`timescale 1ns/10ps
module acs_analog_model (
  // Clock
  input wire logic clock,
  // Sequencer side
  input wire logic convActive,
  input wire logic sampleHold,
  input wire logic [3:0] channelSelect,
  output logic [9:0] resultIn
);
  logic [3:0] held = 4'h0;
  logic [9:0] junk = 10'h155;
  // Channel frozen at the hold pulse, later moves do not disturb it
  always @(posedge clock)
  begin
    if (sampleHold)
      held <= channelSelect;
    junk <= ~junk;
  end
  // Outside a conversion the comparator output is meaningless
  assign resultIn = convActive ? {held, ~held, 2'h1} : junk;
endmodule : acs_analog_model

// ==== test/tb_acs_sequencer.sv ====
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`include "acs_consts.svh"
module tb_acs_sequencer;
  // Divide by four keeps runs short; all 10 result bits are still checked
  localparam int HALF = 2;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] trigIn = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, analogEnable, convClock;
  logic sampleHold, convActive, conversionDoneFlag, prevAct, left, seen;
  logic [1:0] bresp, rresp, referenceSelect, resp;
  logic [31:0] rdata, rd;
  logic [3:0] channelSelect, ch;
  logic [9:0] resultIn;
  logic [15:0] seed = 16'h04d4;
  int miscompares = 0;
  int total_checks = 0;
  int nConv = 0;
  int cnt = 0;
  int lenAt = 0;
  int shAt = 0;
  int n0 = 0;
  int nHold = 0;

  acs_sequencer #(.TRIG_N(8)) acs_sequencer_inst (.clock, .rstn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .trigIn, .resultIn, .analogEnable, .convClock, .sampleHold, .convActive,
    .channelSelect, .referenceSelect, .conversionDoneFlag);
  acs_analog_model acs_analog_model_inst (.clock, .convActive, .sampleHold,
    .channelSelect, .resultIn);

  // Clock, 25 ns period
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  // Counts conversions, their length and the hold point
  always @(posedge clock)
  begin
    if (convActive && !prevAct)
      nConv++;
    // Hold taken before this edge's count: cycles since the start
    if (sampleHold)
    begin
      shAt = cnt;
      nHold++;
    end
    if (convActive)
      cnt++;
    else if (cnt != 0)
    begin
      lenAt = cnt;
      cnt = 0;
    end
    prevAct = convActive;
  end

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext

  task automatic compareVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compareVal

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task automatic rdReg(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : rdReg

  // Bounded wait for the done flag, then let the monitor settle
  task automatic waitDone;
    repeat (3000)
    begin
      @(posedge clock);
      if (conversionDoneFlag === 1'b1)
        break;
    end
    repeat (3) @(posedge clock);
  endtask : waitDone

  // Lengths and hold points given in converter half cycles
  task automatic checkTiming(input int len, input int sh);
    compareVal(lenAt, len * HALF);
    compareVal(shAt, sh * HALF);
  endtask : checkTiming

  task automatic checkResult(input logic [3:0] c, input logic l);
    logic [9:0] r;
    r = {c, ~c, 2'h1};
    rdReg(`ACS_OFF_RESL);
    compareVal(rd, l ? {24'h0, r[1:0], 6'h00} : {24'h0, r[7:0]});
    rdReg(`ACS_OFF_RESH);
    compareVal(rd, l ? {24'h0, r[9:2]} : {30'h0, r[9:8]});
  endtask : checkResult

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clock);
    miscompares++;
    complete_run;
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rdReg(`ACS_OFF_CTRLA);
    compareVal(rd, 32'h0000_0000);
    rdReg(8'h40);
    compareVal({30'h0, resp}, {30'h0, `ACS_RESP_SLVERR});
    // Power reduced: nothing may start or apply
    wr(`ACS_OFF_PWR, 32'h0000_0001);
    compareVal({30'h0, resp}, {30'h0, `ACS_RESP_OKAY});
    wr(`ACS_OFF_CHREF, 32'h0000_0089);
    wr(`ACS_OFF_CTRLA, 32'h0000_0013);
    repeat (40) @(posedge clock);
    compareVal({31'h0, analogEnable}, 32'h0);
    compareVal(nConv, 0);
    compareVal({28'h0, channelSelect}, 32'h0);
    compareVal({30'h0, referenceSelect}, 32'h0);
    wr(`ACS_OFF_CTRLA, 32'h0000_0000);
    wr(`ACS_OFF_PWR, 32'h0000_0000);
    wr(`ACS_OFF_CTRLA, 32'h0000_0011);
    wr(`ACS_OFF_CTRLA, 32'h0000_0013);
    rdReg(`ACS_OFF_CTRLA);
    compareVal(rd & 32'h0000_0002, 32'h0000_0002);
    compareVal({28'h0, channelSelect}, 32'h0000_0009);
    compareVal({30'h0, referenceSelect}, 32'h0000_0002);
    compareVal({31'h0, analogEnable}, 32'h0000_0001);
    waitDone;
    checkTiming(50, 27);
    rdReg(`ACS_OFF_CTRLA);
    compareVal(rd & 32'h0000_000a, 32'h0000_0008);
    checkResult(4'h9, 1'b0);
    // Random channels, moved while the conversion runs
    repeat (4)
    begin
      seed = lfsrNext(seed);
      ch = seed[3:0];
      left = seed[4];
      wr(`ACS_OFF_CHREF, {26'h0, left, 1'b0, ch});
      wr(`ACS_OFF_CTRLA, 32'h0000_001b);
      repeat (8) @(posedge clock);
      wr(`ACS_OFF_CHREF, {26'h0, left, 1'b0, ~ch});
      compareVal({28'h0, channelSelect}, {28'h0, ch});
      waitDone;
      checkTiming(26, 3);
      compareVal({28'h0, channelSelect}, {28'h0, ~ch});
      checkResult(ch, left);
    end
    // Low byte read blocks, high byte read releases
    rdReg(`ACS_OFF_RESL);
    wr(`ACS_OFF_CTRLA, 32'h0000_001b);
    waitDone;
    compareVal({31'h0, conversionDoneFlag}, 32'h0000_0001);
    checkResult(ch, left);
    wr(`ACS_OFF_CTRLA, 32'h0000_001b);
    waitDone;
    checkResult(~ch, left);
    // Trigger edge starts one conversion, a second edge is ignored
    wr(`ACS_OFF_CTRLB, 32'h0000_0001);
    wr(`ACS_OFF_CTRLA, 32'h0000_001d);
    n0 = nConv;
    trigIn[1] <= 1'b1;
    // Three synchroniser stages plus the state register
    repeat (`ACS_SYNC_STAGES + 1) @(posedge clock);
    compareVal({31'h0, convActive}, 32'h0000_0000);
    @(posedge clock);
    compareVal({31'h0, convActive}, 32'h0000_0001);
    repeat (15) @(posedge clock);
    trigIn[1] <= 1'b0;
    @(posedge clock);
    trigIn[1] <= 1'b1;
    waitDone;
    repeat (100) @(posedge clock);
    checkTiming(27, 4);
    compareVal(nConv - n0, 1);
    wr(`ACS_OFF_CTRLA, 32'h0000_001f);
    waitDone;
    repeat (100) @(posedge clock);
    compareVal(nConv - n0, 2);
    // Own done flag as source: back-to-back without clearing
    wr(`ACS_OFF_CTRLB, 32'h0000_0000);
    wr(`ACS_OFF_CTRLA, 32'h0000_0017);
    // Busy never drops here, so hold pulses count the conversions
    n0 = nHold;
    repeat (400) @(posedge clock);
    compareVal({31'h0, nHold - n0 >= 5}, 32'h0000_0001);
    rdReg(`ACS_OFF_CTRLA);
    compareVal(rd & 32'h0000_0002, 32'h0000_0002);
    // Disabled: prescaler held, converter clock quiet
    wr(`ACS_OFF_CTRLA, 32'h0000_0000);
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge clock);
      seen = seen | convClock | convActive;
    end
    compareVal({31'h0, seen}, 32'h0000_0000);
    complete_run;
  end
endmodule : tb_acs_sequencer
